// File: rtl/camd_br_if.sv
// Purpose: Carries branch operands and result between decoder parts
// Assumes: Purely combinational result path
// Notes:   Decoder drives operands, evaluator answers
`default_nettype none

interface camd_br_if;
  import camd_pkg::*;
  camd_cond_t  cond;     // Condition to test
  logic [4:0]  flags;    // H, I, N, Z, C
  logic        irqLine;  // Sampled interrupt line
  logic        bitVal;   // Tested memory bit
  logic [15:0] pcNext;   // Address after the jump
  logic [7:0]  offset;   // Signed relative offset
  logic        taken;    // Condition holds
  logic [15:0] target;   // Branch destination

  modport dec  (output cond, flags, irqLine, bitVal, pcNext, offset,
                input taken, target);
  modport eval (input cond, flags, irqLine, bitVal, pcNext, offset,
                output taken, target);
endinterface

`default_nettype wire

// File: rtl/camd_branch_eval.sv
// Purpose: Evaluates jump conditions and forms the relative target
// Assumes: Flags are H, I, N, Z, C from high bit to low
// Notes:   Combinational only
`default_nettype none

module camd_branch_eval
  import camd_pkg::*;
(
  // Branch operands and result
  camd_br_if.eval br
);

  // Flag aliases
  logic fH, fI, fN, fZ, fC;
  assign {fH, fI, fN, fZ, fC} = br.flags;

  // -------------------------------------------------------------
  // Condition test
  // -------------------------------------------------------------
  always_comb begin
    unique case (br.cond)
      CND_ALWAYS: br.taken = 1'b1;
      CND_NEVER:  br.taken = 1'b0;
      CND_H:      br.taken = fH;
      CND_NH:     br.taken = !fH;
      CND_M:      br.taken = fI;
      CND_NM:     br.taken = !fI;
      CND_MI:     br.taken = fN;
      CND_PL:     br.taken = !fN;
      CND_EQ:     br.taken = fZ;
      CND_NE:     br.taken = !fZ;
      CND_C:      br.taken = fC;
      CND_NC:     br.taken = !fC;
      CND_UGT:    br.taken = !(fC | fZ);
      CND_ULE:    br.taken = fC | fZ;
      CND_IH:     br.taken = br.irqLine;
      CND_IL:     br.taken = !br.irqLine;
      CND_BSET:   br.taken = br.bitVal;
      CND_BCLR:   br.taken = !br.bitVal;
      default:    br.taken = 1'b0;
    endcase
  end

  // Signed offset added to the following instruction address
  assign br.target = br.pcNext + {{8{br.offset[7]}}, br.offset};

endmodule

`default_nettype wire

// File: rtl/camd_decoder.sv
// Purpose: Fetches prefix, opcode and operand bytes, forms addresses
// Assumes: Core classifies the opcode it sees on opcodeOut
// Notes:   One memory read outstanding; data valid with memAck
`default_nettype none

module camd_decoder
  import camd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Instruction start
  input  wire logic        instStart,
  input  wire logic [15:0] startPc,
  // Opcode classification from the core
  input  wire camd_mode_t  modeIn,
  input  wire camd_cond_t  condIn,
  input  wire logic        opRmw,
  input  wire logic        opBcp,
  input  wire logic        opBitTest,
  input  wire logic [2:0]  bitSel,
  // Core state
  input  wire logic [7:0]  idxMain,
  input  wire logic [7:0]  idxAlt,
  input  wire logic [7:0]  accIn,
  input  wire logic [4:0]  flagsIn,
  input  wire logic        irqLine,
  // Memory read port
  output logic             memReq,
  output logic [15:0]      memAddr,
  input  wire logic [7:0]  memRdata,
  input  wire logic        memAck,
  // Decode results
  output logic             busy,
  output logic [7:0]       opcodeOut,
  output logic             opcodeStb,
  output logic             altIdx,
  output logic [15:0]      eaOut,
  output logic             doneStb,
  output logic [2:0]       instLen,
  output logic             modeErr,
  output logic             branchTaken,
  output logic [15:0]      targetPc,
  output logic [15:0]      nextPc,
  output logic             flagN,
  output logic             flagZ,
  output logic             flagC,
  output logic             nzValid,
  output logic             cValid
);

  // -------------------------------------------------------------
  // State and working registers
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_OPC, S_CLS, S_ARG1, S_ARG2, S_OFS, S_PHI, S_PLO,
    S_ROFS, S_EA, S_OPER, S_DONE
  } camd_state_t;

  camd_state_t state_reg;     // Sequencer state
  camd_state_t state_next;    // Next sequencer state
  camd_mode_t  mode_reg;      // Effective mode after prefix
  camd_mode_t  mode_next;     // Mode derived from prefix
  camd_cond_t  cond_reg;      // Captured condition
  logic [7:0]  pfx_reg;       // Prefix seen, or none
  logic [15:0] pc_reg;        // Next byte to fetch
  logic [2:0]  len_reg;       // Bytes consumed
  logic [7:0]  arg1_reg;      // First byte after opcode
  logic [7:0]  arg2_reg;      // Second byte after opcode
  logic [7:0]  ptrHi_reg;     // Pointer high byte
  logic [7:0]  ptrLo_reg;     // Pointer low byte
  logic [7:0]  ofs_reg;       // Relative offset
  logic [7:0]  oper_reg;      // Memory operand
  logic        alt_reg;       // Alternate index selected
  logic        bcp_reg;       // Bit compare operation
  logic        btst_reg;      // Bit test operation
  logic [2:0]  bsel_reg;      // Tested bit
  logic        err_next;      // Long form refused
  logic [15:0] addr_next;     // Next read address
  logic [15:0] eaComb;        // Effective address
  logic [7:0]  idx;           // Selected index value
  logic        isRel;         // Mode ends in a jump
  logic        isWordPtr;     // Pointer is a word
  logic        isPfx;         // Byte is a prefix code
  logic [7:0]  bcpRes;        // Bit compare result

  camd_br_if br ();

  // Branch evaluator
  camd_branch_eval u_eval (
    .br (br)
  );

  assign idx       = alt_reg ? idxAlt : idxMain;
  assign isRel     = mode_reg inside {MD_REL, MD_REL_IND, MD_BITREL,
                                      MD_BITREL_IND};
  assign isWordPtr = mode_reg inside {MD_IND_L, MD_IIDX_L};
  assign isPfx     = memRdata inside {PFX_ALT, PFX_IND_ALT, PFX_IND};
  assign bcpRes    = accIn & oper_reg;

  // Branch operands
  assign br.cond    = cond_reg;
  assign br.flags   = flagsIn;
  assign br.irqLine = irqLine;
  assign br.bitVal  = oper_reg[bsel_reg];
  assign br.pcNext  = pc_reg;
  assign br.offset  = ofs_reg;

  // -------------------------------------------------------------
  // Prefix translation of the base mode
  // -------------------------------------------------------------
  always_comb begin
    mode_next = modeIn;
    if (pfx_reg == PFX_IND) begin
      unique case (modeIn)
        MD_DIR_S:  mode_next = MD_IND_S;
        MD_DIR_L:  mode_next = MD_IND_L;
        MD_BIT:    mode_next = MD_BIT_IND;
        MD_BITREL: mode_next = MD_BITREL_IND;
        MD_REL:    mode_next = MD_REL_IND;
        MD_IDX_S:  mode_next = MD_IIDX_S;
        MD_IDX_L:  mode_next = MD_IIDX_L;
        default:   mode_next = modeIn;
      endcase
    end else if (pfx_reg == PFX_IND_ALT) begin
      if (modeIn == MD_IDX_S) begin
        mode_next = MD_IIDX_S;
      end else if (modeIn == MD_IDX_L) begin
        mode_next = MD_IIDX_L;
      end
    end
    // Memory-to-memory operations reject long forms
    err_next = opRmw && (mode_next inside {MD_DIR_L, MD_IDX_L,
                                          MD_IND_L, MD_IIDX_L});
  end

  // -------------------------------------------------------------
  // Effective address
  // -------------------------------------------------------------
  always_comb begin
    unique case (mode_reg)
      MD_IMM, MD_DIR_L: eaComb = {arg1_reg, arg2_reg};
      MD_IDX0:  eaComb = {PAGE_ZERO, idx};
      MD_IDX_S: eaComb = {PAGE_ZERO, arg1_reg} + {PAGE_ZERO, idx};
      MD_IDX_L: eaComb = {arg1_reg, arg2_reg} + {PAGE_ZERO, idx};
      MD_IND_S, MD_BIT_IND, MD_BITREL_IND:
        eaComb = {PAGE_ZERO, ptrHi_reg};
      MD_IND_L: eaComb = {ptrHi_reg, ptrLo_reg};
      MD_IIDX_S: eaComb = {PAGE_ZERO, ptrHi_reg} + {PAGE_ZERO, idx};
      MD_IIDX_L: eaComb = {ptrHi_reg, ptrLo_reg} + {PAGE_ZERO, idx};
      MD_REL, MD_REL_IND: eaComb = br.target;
      default:  eaComb = {PAGE_ZERO, arg1_reg};
    endcase
  end

  // -------------------------------------------------------------
  // Sequencer next state and read address
  // -------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    addr_next  = memAddr;
    unique case (state_reg)
      S_IDLE: begin
        if (instStart) begin
          state_next = S_OPC;
          addr_next  = startPc;
        end
      end
      S_OPC: begin
        if (memAck) begin
          addr_next = memAddr + 16'h0001;
          // Only one prefix per instruction
          if (!(isPfx && pfx_reg == PFX_NONE)) begin
            state_next = S_CLS;
          end
        end
      end
      S_CLS: begin
        if (err_next || mode_next inside {MD_INH, MD_IDX0, MD_IMM}) begin
          state_next = err_next ? S_DONE : S_EA;
        end else begin
          state_next = S_ARG1;
          addr_next  = pc_reg;
        end
      end
      S_ARG1: begin
        if (memAck) begin
          unique case (mode_reg)
            MD_DIR_L, MD_IDX_L: begin
              state_next = S_ARG2;
              addr_next  = pc_reg + 16'h0001;
            end
            MD_BITREL, MD_BITREL_IND: begin
              state_next = S_OFS;
              addr_next  = pc_reg + 16'h0001;
            end
            MD_IND_S, MD_IND_L, MD_IIDX_S, MD_IIDX_L, MD_BIT_IND: begin
              state_next = S_PHI;
              addr_next  = {PAGE_ZERO, memRdata};
            end
            MD_REL_IND: begin
              state_next = S_ROFS;
              addr_next  = {PAGE_ZERO, memRdata};
            end
            default: state_next = S_EA;
          endcase
        end
      end
      S_ARG2: begin
        if (memAck) begin
          state_next = S_EA;
        end
      end
      S_OFS: begin
        if (memAck) begin
          if (mode_reg == MD_BITREL_IND) begin
            state_next = S_PHI;
            addr_next  = {PAGE_ZERO, arg1_reg};
          end else begin
            state_next = S_EA;
          end
        end
      end
      S_PHI: begin
        if (memAck) begin
          state_next = isWordPtr ? S_PLO : S_EA;
          addr_next  = memAddr + 16'h0001;
        end
      end
      S_PLO, S_ROFS: begin
        if (memAck) begin
          state_next = S_EA;
        end
      end
      S_EA: begin
        if ((bcp_reg || btst_reg) && !isRel && mode_reg != MD_IMM) begin
          state_next = S_OPER;
          addr_next  = eaComb;
        end else if ((btst_reg || bcp_reg) && mode_reg inside {MD_BITREL,
                     MD_BITREL_IND, MD_IMM}) begin
          state_next = S_OPER;
          addr_next  = (mode_reg == MD_IMM) ? eaComb : {PAGE_ZERO,
                       (mode_reg == MD_BITREL) ? arg1_reg : ptrHi_reg};
        end else begin
          state_next = S_DONE;
        end
      end
      S_OPER: begin
        if (memAck) begin
          state_next = S_DONE;
        end
      end
      S_DONE: state_next = S_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Memory port, held until acknowledged
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      memReq  <= 1'b0;
      memAddr <= 16'h0000;
    end else begin
      memReq  <= state_next inside {S_OPC, S_ARG1, S_ARG2, S_OFS, S_PHI,
                                    S_PLO, S_ROFS, S_OPER};
      memAddr <= addr_next;
    end
  end

  // -------------------------------------------------------------
  // Instruction bytes, counter and classification
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pfx_reg   <= PFX_NONE;
      pc_reg    <= 16'h0000;
      len_reg   <= 3'h0;
      opcodeOut <= 8'h00;
      mode_reg  <= MD_INH;
      cond_reg  <= CND_NEVER;
      alt_reg   <= 1'b0;
      bcp_reg   <= 1'b0;
      btst_reg  <= 1'b0;
      bsel_reg  <= 3'h0;
      arg1_reg  <= 8'h00;
      arg2_reg  <= 8'h00;
    end else begin
      if (state_reg == S_IDLE && instStart) begin
        pfx_reg <= PFX_NONE;
        pc_reg  <= startPc;
        len_reg <= 3'h0;
      end
      if (state_reg == S_OPC && memAck) begin
        pc_reg  <= pc_reg + 16'h0001;
        len_reg <= len_reg + LEN_ONE;
        if (isPfx && pfx_reg == PFX_NONE) begin
          pfx_reg <= memRdata;
        end else begin
          opcodeOut <= memRdata;
        end
      end
      if (state_reg == S_CLS) begin
        mode_reg <= mode_next;
        cond_reg <= condIn;
        alt_reg  <= pfx_reg inside {PFX_ALT, PFX_IND_ALT};
        bcp_reg  <= opBcp;
        btst_reg <= opBitTest;
        bsel_reg <= bitSel;
        if (mode_next == MD_IMM) begin
          {arg1_reg, arg2_reg} <= pc_reg;
          pc_reg  <= pc_reg + 16'h0001;
          len_reg <= len_reg + LEN_ONE;
        end
      end
      if (memAck && state_reg inside {S_ARG1, S_ARG2, S_OFS}) begin
        pc_reg  <= pc_reg + 16'h0001;
        len_reg <= len_reg + LEN_ONE;
      end
      if (memAck && state_reg == S_ARG1) begin
        arg1_reg <= memRdata;
      end
      if (memAck && state_reg == S_ARG2) begin
        arg2_reg <= memRdata;
      end
    end
  end

  // Opcode strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      opcodeStb <= 1'b0;
    end else begin
      opcodeStb <= state_reg == S_OPC && memAck && state_next == S_CLS;
    end
  end

  // -------------------------------------------------------------
  // Pointer, offset and operand capture
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ptrHi_reg <= 8'h00;
      ptrLo_reg <= 8'h00;
      ofs_reg   <= 8'h00;
      oper_reg  <= 8'h00;
    end else if (memAck) begin
      if (state_reg == S_PHI) begin
        ptrHi_reg <= memRdata;
      end
      if (state_reg == S_PLO) begin
        ptrLo_reg <= memRdata;
      end
      if (state_reg == S_OFS || state_reg == S_ROFS ||
          (state_reg == S_ARG1 && mode_reg == MD_REL)) begin
        ofs_reg <= memRdata;
      end
      if (state_reg == S_OPER) begin
        oper_reg <= memRdata;
      end
    end
  end

  // -------------------------------------------------------------
  // Result outputs, loaded at the end of each instruction
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      doneStb     <= 1'b0;
      eaOut       <= 16'h0000;
      instLen     <= 3'h0;
      modeErr     <= 1'b0;
      altIdx      <= 1'b0;
      branchTaken <= 1'b0;
      targetPc    <= 16'h0000;
      nextPc      <= 16'h0000;
      flagN       <= 1'b0;
      flagZ       <= 1'b0;
      flagC       <= 1'b0;
      nzValid     <= 1'b0;
      cValid      <= 1'b0;
    end else begin
      doneStb <= state_reg == S_DONE;
      if (state_reg == S_DONE) begin
        eaOut       <= eaComb;
        instLen     <= len_reg;
        modeErr     <= err_next;
        altIdx      <= alt_reg;
        branchTaken <= isRel && br.taken && !err_next;
        targetPc    <= br.target;
        nextPc      <= pc_reg;
        flagN       <= bcpRes[7];
        flagZ       <= bcpRes == 8'h00;
        flagC       <= br.bitVal;
        nzValid     <= bcp_reg && !err_next;
        cValid      <= btst_reg && !err_next;
      end
    end
  end

  // Busy while an instruction is in flight
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= state_next != S_IDLE;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence sDone(camd_mode_t m);
    state_reg == S_DONE && mode_reg == m && pfx_reg == PFX_NONE && !err_next;
  endsequence

  sequence sRmwBad;
    state_reg == S_CLS && err_next ##1 state_reg == S_DONE;
  endsequence

  short_direct_a: assert property (sDone(MD_DIR_S) |=> eaOut[15:8] == 8'h00 && instLen == 3'h2) else $error("short direct address or length wrong");
  long_direct_a: assert property (sDone(MD_DIR_L) |=> instLen == 3'h3) else $error("long direct length wrong");
  idx_zero_a: assert property (sDone(MD_IDX0) |=> instLen == 3'h1 && eaOut[15:8] == 8'h00) else $error("no offset index wrong");
  short_idx_a: assert property (sDone(MD_IDX_S) |=> eaOut <= SHORT_IDX_MAX) else $error("short indexed out of range");
  rel_target_a: assert property (state_reg == S_DONE && isRel |=> targetPc == $past(pc_reg) + {{8{$past(ofs_reg[7])}}, $past(ofs_reg)}) else $error("relative target wrong");
  rmw_refuse_a: assert property (sRmwBad |=> modeErr && doneStb && !branchTaken) else $error("long memory-to-memory not refused");
  alt_prefix_a: assert property (state_reg == S_CLS && pfx_reg == PFX_ALT |=> alt_reg) else $error("alternate prefix ignored");
  mem_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr)) else $error("read dropped before ack");
  eq_branch_a: assert property (state_reg == S_DONE && isRel && cond_reg == CND_EQ && !err_next |=> branchTaken == $past(flagsIn[1])) else $error("equal jump wrong");

endmodule

`default_nettype wire

// File: rtl/camd_pkg.sv
// Purpose: Shared constants and types for the address mode decoder
// Assumes: One clock, byte-wide memory reads held until an ack that may come cycles later
// Notes:   Prefix codes, addressing modes and branch conditions follow
`default_nettype none

package camd_pkg;

  // -------------------------------------------------------------
  // Prefix codes and address constants
  // -------------------------------------------------------------
  localparam logic [7:0]  PFX_NONE    = 8'h00;  // No prefix seen
  localparam logic [7:0]  PFX_ALT     = 8'h90;  // Alternate index
  localparam logic [7:0]  PFX_IND_ALT = 8'h91;  // Indirect on alternate
  localparam logic [7:0]  PFX_IND     = 8'h92;  // Indirect forms
  localparam logic [7:0]  PAGE_ZERO   = 8'h00;  // High byte of page zero
  localparam logic [15:0] SHORT_IDX_MAX = 16'h01FE;  // Short indexed top
  localparam logic [2:0]  LEN_ONE     = 3'h1;   // One byte of length

  // -------------------------------------------------------------
  // Addressing modes, base and prefix-derived
  // -------------------------------------------------------------
  typedef enum logic [4:0] {
    MD_INH, MD_IMM, MD_DIR_S, MD_DIR_L, MD_IDX0, MD_IDX_S, MD_IDX_L,
    MD_REL, MD_BIT, MD_BITREL, MD_IND_S, MD_IND_L, MD_IIDX_S,
    MD_IIDX_L, MD_REL_IND, MD_BIT_IND, MD_BITREL_IND
  } camd_mode_t;

  // -------------------------------------------------------------
  // Branch conditions
  // -------------------------------------------------------------
  typedef enum logic [4:0] {
    CND_ALWAYS, CND_NEVER, CND_H, CND_NH, CND_M, CND_NM, CND_MI,
    CND_PL, CND_EQ, CND_NE, CND_C, CND_NC, CND_UGT, CND_ULE,
    CND_IH, CND_IL, CND_BSET, CND_BCLR
  } camd_cond_t;

endpackage

`default_nettype wire

// File: tb/camd_mem_model.sv
// Purpose: Program and data memory model on the decoder read port
// Assumes: One read at a time; bench fills mem directly
// Notes:   Ack delay rotates 0..3 cycles; released data is inverted
`default_nettype none
module camd_mem_model
(
  // Clock
  input  wire logic        clk_sys,
  // Read port
  input  wire logic        memReq,
  input  wire logic [15:0] memAddr,
  output logic [7:0]       memRdata,
  output logic             memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];  // Byte storage
  logic [1:0] waitCnt = 2'h0; // Cycles left before ack
  logic [1:0] dlyRot  = 2'h0; // Rotating delay source
  initial begin
    memRdata = 8'hA5;
    memAck   = 1'b0;
  end
  // Ack one cycle, then drop it and scramble the data lines
  always @(negedge clk_sys) begin
    if (memAck) begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      dlyRot   <= dlyRot + 2'h1;
      waitCnt  <= dlyRot;
    end else if (memReq && waitCnt != 2'h0) waitCnt <= waitCnt - 2'h1;
    else if (memReq) begin
      memAck   <= 1'b1;
      memRdata <= mem[memAddr];
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the address mode decoder
// Assumes: Memory model answers with varying delay
// Notes:   Expected values come from the model code in run
`default_nettype none
module tb import camd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, nrst = 1'b0, instStart = 1'b0, irqLine = 1'b0;
  logic [15:0] startPc = 16'h0000, memAddr, eaOut, targetPc, nextPc;
  camd_mode_t  modeIn = MD_INH;
  camd_cond_t  condIn = CND_ALWAYS;
  logic        opRmw = 1'b0, opBcp = 1'b0, opBitTest = 1'b0;
  logic [2:0]  bitSel = 3'h0, instLen;
  logic [7:0]  idxMain = 8'h00, idxAlt = 8'h00, accIn = 8'h00, memRdata, opcodeOut;
  logic [4:0]  flagsIn = 5'h00;
  logic        memReq, memAck, busy, opcodeStb, altIdx, doneStb, modeErr, branchTaken;
  logic        flagN, flagZ, flagC, nzValid, cValid;
  int          mismatches = 0, n_tests = 0;
  logic [31:0] seed = 32'h00013CEF; // Start value 81135
  always #12.5 clk_sys = ~clk_sys;
  camd_decoder u_dut (.*);
  camd_mem_model u_mem (.*);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Branch condition model indexed by condition code
  function automatic logic cnd(camd_cond_t c, logic [4:0] f, logic q, logic b);
    logic [17:0] v;
    v = {!b, b, !q, q, f[0] | f[1], !(f[0] | f[1]), !f[0], f[0], !f[1], f[1],
         !f[2], f[2], !f[3], f[3], !f[4], f[4], 1'b0, 1'b1};
    return v[c];
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (e !== s) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One instruction: fill memory, predict, run, compare
  task automatic run(camd_mode_t m, camd_cond_t c, logic [7:0] pfx, logic [2:0] fl);
    logic [15:0] pc, ea, np, nOp;
    logic [7:0]  ix, b1, b2, d, of;
    logic [2:0]  len;
    logic        er;
    seed = lfsr(seed);
    startPc = 16'h1000 + {4'h0, seed[11:0]};
    pc = startPc + 16'(pfx != 8'h00);
    u_mem.mem[startPc] = pfx;
    u_mem.mem[pc] = 8'h20;
    {b2, b1} = seed[27:12];
    u_mem.mem[pc + 16'h1] = b1;
    u_mem.mem[pc + 16'h2] = b2;
    seed = lfsr(seed);
    d = seed[7:0] ^ seed[31:24];
    u_mem.mem[{8'h00, b1}] = d;
    {idxMain, idxAlt, accIn} = seed[23:0];
    {flagsIn, irqLine, bitSel} = seed[31:23];
    modeIn = m;
    condIn = c;
    {opBitTest, opBcp, opRmw} = fl;
    ix = (pfx == PFX_ALT || pfx == PFX_IND_ALT) ? idxAlt : idxMain;
    ea = {8'h00, b1};
    case (m)
      MD_DIR_L: ea = {b1, b2};
      MD_IDX0:  ea = {8'h00, ix};
      MD_IDX_S: ea = ea + {8'h00, ix};
      MD_IDX_L: ea = {b1, b2} + {8'h00, ix};
      default: ;
    endcase
    if (pfx == PFX_IND || (pfx == PFX_IND_ALT && m == MD_IDX_S))
      ea = {8'h00, d} + ((m == MD_IDX_S) ? {8'h00, ix} : 16'h0000);
    len = 3'(pfx != 8'h00) + ((m inside {MD_DIR_L, MD_IDX_L, MD_BITREL}) ? 3'h3 :
          (m == MD_IDX0) ? 3'h1 : 3'h2);
    np = startPc + 16'(len);
    of = (pfx == PFX_IND) ? d : (m == MD_REL) ? b1 : b2;
    er = fl[0] && m == MD_DIR_L;
    instStart = 1'b1;
    @(negedge clk_sys);
    instStart = 1'b0;
    nOp = 16'h0000;
    for (int i = 0; i < 300 && doneStb !== 1'b1; i++) begin
      nOp += 16'(opcodeStb === 1'b1);
      @(negedge clk_sys);
    end
    chk("doneStb", 16'h1, 16'(doneStb));
    chk("opcodeStb", 16'h1, nOp);
    chk("opcodeOut", 16'h20, 16'(opcodeOut));
    chk("busy", 16'h0, 16'(busy));
    chk("modeErr", 16'(er), 16'(modeErr));
    if (!er) begin
      chk("instLen", 16'(len), 16'(instLen));
      chk("altIdx", 16'(pfx == PFX_ALT || pfx == PFX_IND_ALT), 16'(altIdx));
      if (m != MD_REL) chk("eaOut", ea, eaOut);
      chk("nzValid", 16'(fl[1]), 16'(nzValid));
      chk("cValid", 16'(fl[2]), 16'(cValid));
      if (fl[1]) chk("flagNZ", {14'h0, d[7] & accIn[7], (d & accIn) == 8'h00},
                     {14'h0, flagN, flagZ});
      if (fl[2]) chk("flagC", 16'(d[bitSel]), 16'(flagC));
      if (m inside {MD_REL, MD_BITREL}) begin
        chk("nextPc", np, nextPc);
        chk("taken", 16'(cnd(c, flagsIn, irqLine, d[bitSel])), 16'(branchTaken));
        chk("targetPc", np + {{8{of[7]}}, of}, targetPc);
      end
    end
    @(negedge clk_sys);
  endtask
  initial begin
    #200us;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    run(MD_DIR_S, CND_ALWAYS, PFX_NONE, 3'h0);
    run(MD_DIR_L, CND_ALWAYS, PFX_NONE, 3'h0);
    run(MD_IDX0, CND_ALWAYS, PFX_NONE, 3'h0);
    run(MD_IDX_S, CND_ALWAYS, PFX_NONE, 3'h0);
    run(MD_IDX_L, CND_ALWAYS, PFX_NONE, 3'h0);
    run(MD_IDX_S, CND_ALWAYS, PFX_ALT, 3'h0);
    run(MD_DIR_S, CND_ALWAYS, PFX_IND, 3'h0);
    run(MD_DIR_L, CND_ALWAYS, PFX_NONE, 3'h1);
    run(MD_DIR_S, CND_ALWAYS, PFX_NONE, 3'h2);
    run(MD_IDX_S, CND_ALWAYS, PFX_IND, 3'h0);
    run(MD_IDX_S, CND_ALWAYS, PFX_IND_ALT, 3'h0);
    run(MD_REL, CND_NE, PFX_IND, 3'h0);
    for (int k = 0; k < 36; k++) run((k % 18 < 16) ? MD_REL : MD_BITREL,
        camd_cond_t'(k % 18), PFX_NONE, (k % 18 < 16) ? 3'h0 : 3'h4);
    final_report();
  end
endmodule
`default_nettype wire
